// File: flash_guard.sv
// Flash program/erase protection guard with register slave and RAM overlay
`timescale 1ns/1ps
`default_nettype none
module flash_guard (
  input  wire logic                clock,
  input  wire logic                nrst,
  input  wire logic                ce,
  input  wire logic [7:0]          awaddr,
  input  wire logic                awvalid,
  output var  logic                awready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  input  wire logic                wvalid,
  output var  logic                wready,
  output var  logic [1:0]          bresp,
  output var  logic                bvalid,
  input  wire logic                bready,
  input  wire logic [7:0]          araddr,
  input  wire logic                arvalid,
  output var  logic                arready,
  output var  logic [31:0]         rdata,
  output var  logic [1:0]          rresp,
  output var  logic                rvalid,
  input  wire logic                rready,
  input  wire logic                flash_write_enable_pin,
  input  wire logic                watchdog_timer_reset,
  input  wire logic                hw_standby,
  input  wire logic                sw_standby,
  input  wire logic                flash_read,
  input  wire logic                exc_start,
  input  wire logic                exc_excluded,
  input  wire logic                sleep_exec,
  input  wire logic                bus_release,
  input  wire logic                nmi_in,
  input  wire logic                cpu_req,
  input  wire logic [23:0]         cpu_addr,
  output var  logic                nmi_out,
  output var  logic                program_mode,
  output var  logic                erase_mode,
  output var  logic                program_verify_mode,
  output var  logic                erase_verify_mode,
  output var  logic [7:0]          erase_block_en,
  output var  logic                ram_hit,
  output var  logic [9:0]          ram_offset
);
  // ********************************
  // Register state
  // ********************************
  logic [6:0]                      ctrl_one_r;
  logic [6:0]                      ctrl_one_nxt;
  logic [7:0]                      ctrl_two_r;
  logic [7:0]                      ctrl_two_nxt;
  logic [7:0]                      erase_sel_r;
  logic [7:0]                      erase_sel_nxt;
  logic [3:0]                      ovl_r;
  logic [3:0]                      ovl_nxt;
  logic                            err_r;
  logic                            err_nxt;
  flash_guard_pkg::guard_state_t   state_r;
  flash_guard_pkg::guard_state_t   state_nxt;
  logic                            aw_held_r;
  logic [7:0]                      aw_addr_r;
  logic                            w_held_r;
  logic [31:0]                     w_data_r;
  logic [3:0]                      w_strb_r;
  logic [7:0]                      erase_en_nxt;

  // ********************************
  // Bus decode
  // ********************************
  wire        aw_take   = awvalid & awready;
  wire        w_take    = wvalid & wready;
  wire        aw_have   = aw_held_r | aw_take;
  wire        w_have    = w_held_r | w_take;
  wire        do_write  = aw_have & w_have;
  wire [7:0]  wr_addr   = aw_held_r ? aw_addr_r : awaddr;
  wire [31:0] wr_data   = w_held_r ? w_data_r : wdata;
  wire [3:0]  wr_strb   = w_held_r ? w_strb_r : wstrb;
  wire        wr_lane   = do_write & wr_strb[0];
  wire        wr_one    = wr_lane & (wr_addr == flash_guard_pkg::OFF_CTRL_ONE);
  wire        wr_two    = wr_lane & (wr_addr == flash_guard_pkg::OFF_CTRL_TWO);
  wire        wr_erase  = wr_lane & (wr_addr == flash_guard_pkg::OFF_ERASE);
  wire        wr_ovl    = wr_lane & (wr_addr == flash_guard_pkg::OFF_OVERLAY);
  wire        wr_mapped = (wr_addr == flash_guard_pkg::OFF_CTRL_ONE) |
                          (wr_addr == flash_guard_pkg::OFF_CTRL_TWO) |
                          (wr_addr == flash_guard_pkg::OFF_ERASE) |
                          (wr_addr == flash_guard_pkg::OFF_STATUS) |
                          (wr_addr == flash_guard_pkg::OFF_OVERLAY);
  wire        aw_held_nxt = aw_have & ~do_write;
  wire        w_held_nxt  = w_have & ~do_write;
  wire        bvalid_nxt  = do_write | (bvalid & ~bready);
  wire        ar_take     = arvalid & arready;
  wire        rvalid_nxt  = ar_take | (rvalid & ~rready);
  wire [31:0] status_word = {27'h0, program_mode, erase_mode, state_r, err_r};
  wire        rd_one    = araddr == flash_guard_pkg::OFF_CTRL_ONE;
  wire        rd_two    = araddr == flash_guard_pkg::OFF_CTRL_TWO;
  wire        rd_erase  = araddr == flash_guard_pkg::OFF_ERASE;
  wire        rd_stat   = araddr == flash_guard_pkg::OFF_STATUS;
  wire        rd_ovl    = araddr == flash_guard_pkg::OFF_OVERLAY;
  wire [31:0] rd_word   = rd_one   ? {25'h0, ctrl_one_r} :
                          rd_two   ? {24'h000000, ctrl_two_r} :
                          rd_erase ? {24'h000000, erase_sel_r} :
                          rd_stat  ? status_word :
                          rd_ovl   ? {28'h0000000, ovl_r} : 32'h00000000;
  wire        rd_ok     = rd_one | rd_two | rd_erase | rd_stat | rd_ovl;

  // ********************************
  // Protection conditions
  // ********************************
  wire        err_release = watchdog_timer_reset | hw_standby;
  wire        all_standby = hw_standby | sw_standby;
  wire        reg_clear   = err_release | all_standby | ~flash_write_enable_pin;
  wire        busy        = ctrl_one_r[flash_guard_pkg::P_BIT] |
                            ctrl_one_r[flash_guard_pkg::E_BIT];
  wire        err_evt     = busy & (flash_read | (exc_start & ~exc_excluded) |
                            sleep_exec | bus_release);
  wire        ovl_on_nxt  = ovl_nxt[flash_guard_pkg::OVL_SEL_BIT];
  wire        wen_nxt     = ctrl_one_nxt[flash_guard_pkg::WR_EN_BIT];
  wire        ovl_active  = ovl_r[flash_guard_pkg::OVL_SEL_BIT] & flash_write_enable_pin;
  wire        in_ram      = (cpu_addr >= flash_guard_pkg::RAM_BASE) &
                            (cpu_addr <= flash_guard_pkg::RAM_LAST);
  wire        in_window   = cpu_addr[23:10] == {flash_guard_pkg::FLASH_HI,
                            ovl_r[flash_guard_pkg::BLK_MSB:flash_guard_pkg::BLK_LSB]};

  // ********************************
  // Next register values
  // ********************************
  always_comb begin
    ctrl_one_nxt = wr_one ? wr_data[6:0] : ctrl_one_r;
    if (!ctrl_one_nxt[flash_guard_pkg::WR_EN_BIT]) begin
      ctrl_one_nxt[flash_guard_pkg::P_BIT]   = 1'b0;
      ctrl_one_nxt[flash_guard_pkg::E_BIT]   = 1'b0;
      ctrl_one_nxt[flash_guard_pkg::PSU_BIT] = 1'b0;
      ctrl_one_nxt[flash_guard_pkg::ESU_BIT] = 1'b0;
    end
    if (reg_clear) begin
      ctrl_one_nxt = flash_guard_pkg::CTRL_ONE_RST;
    end
  end

  always_comb begin
    ctrl_two_nxt  = wr_two ? wr_data[7:0] : ctrl_two_r;
    erase_sel_nxt = wr_erase ? wr_data[7:0] : erase_sel_r;
    ovl_nxt       = wr_ovl ? wr_data[3:0] : ovl_r;
    if (err_release | all_standby) begin
      ctrl_two_nxt = flash_guard_pkg::CTRL_TWO_RST;
    end
    if (reg_clear) begin
      erase_sel_nxt = flash_guard_pkg::BLKSEL_RST;
    end
  end

  // Error flag: only release events and nrst clear it
  always_comb begin
    err_nxt = err_r | err_evt;
    if (err_release) begin
      err_nxt = 1'b0;
    end
  end

  // ********************************
  // Guard state machine
  // ********************************
  always_comb begin
    unique case (state_r)
      flash_guard_pkg::ST_PROTECTED,
      flash_guard_pkg::ST_READY,
      flash_guard_pkg::ST_ACTIVE,
      flash_guard_pkg::ST_ERROR: begin
        if (err_nxt) begin
          state_nxt = flash_guard_pkg::ST_ERROR;
        end else if (ctrl_one_nxt[flash_guard_pkg::P_BIT] |
                     ctrl_one_nxt[flash_guard_pkg::E_BIT]) begin
          state_nxt = flash_guard_pkg::ST_ACTIVE;
        end else if (wen_nxt) begin
          state_nxt = flash_guard_pkg::ST_READY;
        end else begin
          state_nxt = flash_guard_pkg::ST_PROTECTED;
        end
      end
    endcase
  end

  wire run_ok   = (state_nxt == flash_guard_pkg::ST_ACTIVE) & ~ovl_on_nxt;
  wire pm_nxt   = run_ok & ctrl_one_nxt[flash_guard_pkg::P_BIT];
  wire em_nxt   = run_ok & ctrl_one_nxt[flash_guard_pkg::E_BIT] & (|erase_sel_nxt);
  wire pvm_nxt  = wen_nxt & ctrl_one_nxt[flash_guard_pkg::PGM_VFY_BIT];
  wire evm_nxt  = wen_nxt & ctrl_one_nxt[flash_guard_pkg::ERS_VFY_BIT];
  wire busy_nxt = ctrl_one_nxt[flash_guard_pkg::P_BIT] | ctrl_one_nxt[flash_guard_pkg::E_BIT];
  wire nmi_nxt  = nmi_in & ~busy_nxt & ~err_nxt;
  wire hit_nxt  = cpu_req & (in_ram | (ovl_active & in_window));

  genvar gi;
  generate
    for (gi = 0; gi < flash_guard_pkg::BLKSEL_W; gi++) begin : g_blk
      assign erase_en_nxt[gi] = em_nxt & erase_sel_nxt[gi];
    end
  endgenerate

  // ********************************
  // Flip-flops
  // ********************************
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ctrl_one_r  <= flash_guard_pkg::CTRL_ONE_RST;
      ctrl_two_r  <= flash_guard_pkg::CTRL_TWO_RST;
      erase_sel_r <= flash_guard_pkg::BLKSEL_RST;
      ovl_r       <= flash_guard_pkg::OVL_RST;
      err_r       <= 1'b0;
      state_r     <= flash_guard_pkg::ST_PROTECTED;
    end else if (ce) begin
      ctrl_one_r  <= ctrl_one_nxt;
      ctrl_two_r  <= ctrl_two_nxt;
      erase_sel_r <= erase_sel_nxt;
      ovl_r       <= ovl_nxt;
      err_r       <= err_nxt;
      state_r     <= state_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      program_mode        <= 1'b0;
      erase_mode          <= 1'b0;
      program_verify_mode <= 1'b0;
      erase_verify_mode   <= 1'b0;
      erase_block_en      <= 8'h00;
      nmi_out             <= 1'b0;
      ram_hit             <= 1'b0;
      ram_offset          <= 10'h000;
    end else if (ce) begin
      program_mode        <= pm_nxt;
      erase_mode          <= em_nxt;
      program_verify_mode <= pvm_nxt;
      erase_verify_mode   <= evm_nxt;
      erase_block_en      <= erase_en_nxt;
      nmi_out             <= nmi_nxt;
      ram_hit             <= hit_nxt;
      ram_offset          <= cpu_addr[9:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_held_r  <= 1'b0;
      w_data_r  <= 32'h00000000;
      w_strb_r  <= 4'h0;
      awready   <= 1'b0;
      wready    <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= flash_guard_pkg::RESP_OKAY;
      arready   <= 1'b0;
      rvalid    <= 1'b0;
      rdata     <= 32'h00000000;
      rresp     <= flash_guard_pkg::RESP_OKAY;
    end else if (ce) begin
      aw_held_r <= aw_held_nxt;
      w_held_r  <= w_held_nxt;
      if (aw_take) begin
        aw_addr_r <= awaddr;
      end
      if (w_take) begin
        w_data_r <= wdata;
        w_strb_r <= wstrb;
      end
      awready <= ~aw_held_nxt & ~bvalid_nxt;
      wready  <= ~w_held_nxt & ~bvalid_nxt;
      bvalid  <= bvalid_nxt;
      if (do_write) begin
        bresp <= wr_mapped ? flash_guard_pkg::RESP_OKAY : flash_guard_pkg::RESP_SLVERR;
      end
      arready <= ~rvalid_nxt;
      rvalid  <= rvalid_nxt;
      if (ar_take) begin
        rdata <= rd_word;
        rresp <= rd_ok ? flash_guard_pkg::RESP_OKAY : flash_guard_pkg::RESP_SLVERR;
      end
    end
  end

  // ********************************
  // Checks
  // ********************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_fault;
    ce & err_evt & ~err_release & ~all_standby & flash_write_enable_pin & ~do_write;
  endsequence
  sequence s_modes_off;
    !program_mode && !erase_mode && erase_block_en == 8'h00;
  endsequence

  property p_pin_low_clears;
    ce && !flash_write_enable_pin |=> ctrl_one_r == 7'h00 && erase_sel_r == 8'h00
      && !program_mode && !program_verify_mode && !erase_verify_mode;
  endproperty
  a_pin_low_clears: assert property (p_pin_low_clears)
    else $error("pin low did not clear control state");

  property p_standby_clears;
    ce && (sw_standby || hw_standby || watchdog_timer_reset) |=>
      ctrl_one_r == 7'h00 && ctrl_two_r == 8'h00 && erase_sel_r == 8'h00;
  endproperty
  a_standby_clears: assert property (p_standby_clears)
    else $error("standby or reset did not clear registers");

  property p_abort_keeps;
    s_fault |=> s_modes_off and err_r && ctrl_one_r == $past(ctrl_one_r)
      && erase_sel_r == $past(erase_sel_r);
  endproperty
  a_abort_keeps: assert property (p_abort_keeps)
    else $error("fault did not abort with settings kept");

  property p_flag_raised;
    ce && busy && (flash_read || sleep_exec || bus_release || (exc_start && !exc_excluded))
      && !err_release |=> err_r;
  endproperty
  a_flag_raised: assert property (p_flag_raised)
    else $error("error flag not raised by fault event");

  property p_excluded_exc;
    ce && !err_r && busy && exc_start && exc_excluded && !flash_read && !sleep_exec
      && !bus_release |=> !err_r;
  endproperty
  a_excluded_exc: assert property (p_excluded_exc)
    else $error("excluded exception raised error flag");

  property p_flag_sticky;
    err_r && !(ce && err_release) |=> err_r;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("error flag dropped without release");

  property p_flag_release;
    ce && err_release |=> !err_r ##1 !err_r || $past(busy);
  endproperty
  a_flag_release: assert property (p_flag_release)
    else $error("release did not clear error flag");

  property p_error_no_mode;
    err_r |-> s_modes_off and state_r == flash_guard_pkg::ST_ERROR;
  endproperty
  a_error_no_mode: assert property (p_error_no_mode)
    else $error("program or erase mode in error protection");

  property p_error_verify;
    err_r && ctrl_one_r[flash_guard_pkg::WR_EN_BIT] |->
      program_verify_mode == ctrl_one_r[flash_guard_pkg::PGM_VFY_BIT] &&
      erase_verify_mode == ctrl_one_r[flash_guard_pkg::ERS_VFY_BIT];
  endproperty
  a_error_verify: assert property (p_error_verify)
    else $error("verify blocked in error protection");

  property p_nmi_blocked;
    busy || err_r |-> !nmi_out;
  endproperty
  a_nmi_blocked: assert property (p_nmi_blocked)
    else $error("NMI passed while busy");

  property p_block_gate;
    (erase_block_en & ~erase_sel_r) == 8'h00 && (erase_sel_r != 8'h00 || !erase_mode);
  endproperty
  a_block_gate: assert property (p_block_gate)
    else $error("erase enabled for unselected block");

  property p_overlay_protects;
    ovl_r[flash_guard_pkg::OVL_SEL_BIT] |-> !program_mode && !erase_mode;
  endproperty
  a_overlay_protects: assert property (p_overlay_protects)
    else $error("program or erase under overlay select");

  property p_enable_clears;
    !ctrl_one_r[flash_guard_pkg::WR_EN_BIT] |->
      !ctrl_one_r[flash_guard_pkg::P_BIT] && !ctrl_one_r[flash_guard_pkg::E_BIT];
  endproperty
  a_enable_clears: assert property (p_enable_clears)
    else $error("program or erase bit without software enable");

  property p_overlay_removed;
    ce && !flash_write_enable_pin && cpu_req && !in_ram |=> !ram_hit;
  endproperty
  a_overlay_removed: assert property (p_overlay_removed)
    else $error("overlay active with pin low");

  property p_window_hit;
    ce && cpu_req && ovl_active && in_window |=> ram_hit && ram_offset == $past(cpu_addr[9:0]);
  endproperty
  a_window_hit: assert property (p_window_hit)
    else $error("overlay window access missed RAM");

endmodule : flash_guard
`default_nettype wire

// File: flash_guard_pkg.sv
// Constants and types shared by the flash program/erase guard
package flash_guard_pkg;
  // ********************************
  // Register map
  // ********************************
  localparam int unsigned ADDR_W       = 8;
  localparam int unsigned DATA_W       = 32;
  localparam logic [7:0]  OFF_CTRL_ONE = 8'h00;
  localparam logic [7:0]  OFF_CTRL_TWO = 8'h04;
  localparam logic [7:0]  OFF_ERASE    = 8'h08;
  localparam logic [7:0]  OFF_STATUS   = 8'h0C;
  localparam logic [7:0]  OFF_OVERLAY  = 8'h10;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  // ********************************
  // Field layout and reset values
  // ********************************
  localparam int unsigned CTRL_ONE_W   = 7;
  localparam int unsigned P_BIT        = 0;
  localparam int unsigned E_BIT        = 1;
  localparam int unsigned PGM_VFY_BIT  = 2;
  localparam int unsigned ERS_VFY_BIT  = 3;
  localparam int unsigned PSU_BIT      = 4;
  localparam int unsigned ESU_BIT      = 5;
  localparam int unsigned WR_EN_BIT    = 6;
  localparam logic [6:0]  CTRL_ONE_RST = 7'h00;
  localparam int unsigned CTRL_TWO_W   = 8;
  localparam logic [7:0]  CTRL_TWO_RST = 8'h00;
  localparam int unsigned BLKSEL_W     = 8;
  localparam logic [7:0]  BLKSEL_RST   = 8'h00;
  localparam int unsigned OVL_W        = 4;
  localparam logic [3:0]  OVL_RST      = 4'h0;
  localparam int unsigned OVL_SEL_BIT  = 0;
  localparam int unsigned BLK_LSB      = 1;
  localparam int unsigned BLK_MSB      = 3;
  localparam int unsigned STAT_ERR_BIT = 0;
  localparam int unsigned STAT_ST_LSB  = 1;
  localparam int unsigned STAT_PM_BIT  = 4;
  localparam int unsigned STAT_EM_BIT  = 3;
  // ********************************
  // Overlay window and timing
  // ********************************
  localparam int unsigned CPU_ADDR_W   = 24;
  localparam int unsigned WIN_W        = 10;
  localparam logic [23:0] RAM_BASE     = 24'hFFF000;
  localparam logic [23:0] RAM_LAST     = 24'hFFF3FF;
  localparam logic [10:0] FLASH_HI     = 11'h000;
  localparam int unsigned EXT_RESET_MIN_CYCLES = 20;
  // ********************************
  // Guard state
  // ********************************
  typedef enum logic [1:0] {
    ST_PROTECTED = 2'h0,
    ST_READY     = 2'h1,
    ST_ACTIVE    = 2'h3,
    ST_ERROR     = 2'h2
  } guard_state_t;
endpackage : flash_guard_pkg

// File: cpu_fault_model.sv
// CPU-side model that raises fault events toward the flash guard
`timescale 1ns/1ps
`default_nettype none
module cpu_fault_model (
  input  wire logic       clock,
  input  wire logic [2:0] cmd,
  output var  logic       flash_read,
  output var  logic       exc_start,
  output var  logic       exc_excluded,
  output var  logic       sleep_exec,
  output var  logic       bus_release
);
  // ********************************
  // One-cycle event pulses
  // ********************************
  logic [4:0] ev_r = 5'h00;
  always_ff @(posedge clock) begin
    ev_r <= {cmd == 3'h1, cmd == 3'h2 || cmd == 3'h5, cmd == 3'h5, cmd == 3'h3, cmd == 3'h4};
  end
  assign flash_read   = ev_r[4];
  assign exc_start    = ev_r[3];
  assign exc_excluded = ev_r[2];
  assign sleep_exec   = ev_r[1];
  assign bus_release  = ev_r[0];
endmodule : cpu_fault_model
`default_nettype wire

// File: testbench.sv
// Register-level testbench for the flash program/erase guard
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ********************************
  // Stimulus and wiring
  // ********************************
  logic clock = 0, nrst = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic we_pin = 1, ce = 1, wdr = 0, hws = 0, sws = 0, nmi_in = 1, cpu_req = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rd_v;
  logic [23:0] cpu_addr = 24'h000000;
  logic [2:0] cmd = 3'h0;
  logic [1:0] resp, bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, nmi_out, pm, em, pvm, evm, hit;
  logic fr, es, ex, se, br;
  logic [31:0] rdata;
  logic [7:0] blk_en;
  logic [9:0] ofs;
  int n_errors = 0, total_checks = 0, i;
  initial forever #12.5 clock = ~clock;
  cpu_fault_model i_cpu_fault_model (.clock(clock), .cmd(cmd), .flash_read(fr), .exc_start(es),
    .exc_excluded(ex), .sleep_exec(se), .bus_release(br));
  flash_guard i_flash_guard (.clock(clock), .nrst(nrst), .ce(ce), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .flash_write_enable_pin(we_pin), .watchdog_timer_reset(wdr),
    .hw_standby(hws), .sw_standby(sws), .flash_read(fr), .exc_start(es), .exc_excluded(ex),
    .sleep_exec(se), .bus_release(br), .nmi_in(nmi_in), .cpu_req(cpu_req),
    .cpu_addr(cpu_addr), .nmi_out(nmi_out), .program_mode(pm), .erase_mode(em),
    .program_verify_mode(pvm), .erase_verify_mode(evm), .erase_block_en(blk_en),
    .ram_hit(hit), .ram_offset(ofs));
  // ********************************
  // Bus tasks and checks
  // ********************************
  task automatic close_out();
    if (n_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic timeout(input int n);
    if (n >= 50) begin
      chk(32'h1, 32'h0, "bus timeout");
      close_out();
    end
  endtask : timeout
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    @(posedge clock);
    for (i = 0; i < 50 && bready; i++) begin
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) begin
        bready <= 0;
        resp = bresp;
      end
      @(posedge clock);
    end
    timeout(i);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    araddr <= a; arvalid <= 1; rready <= 1;
    @(posedge clock);
    for (i = 0; i < 50 && rready; i++) begin
      if (arready) arvalid <= 0;
      if (rvalid) begin
        rready <= 0;
        rd_v = rdata;
        resp = rresp;
      end
      @(posedge clock);
    end
    timeout(i);
  endtask : rd
  task automatic settle();
    repeat (3) @(posedge clock);
  endtask : settle
  task automatic pulse(input int which);
    @(posedge clock);
    if (which == 0) wdr <= 1; else hws <= 1;
    @(posedge clock);
    wdr <= 0; hws <= 0;
    settle();
  endtask : pulse
  // ********************************
  // Main sequence
  // ********************************
  initial begin
    repeat (20) @(posedge clock);
    nrst <= 1;
    settle();
    rd(8'h00); chk(rd_v, 32'h0, "ctrl one reset");
    chk(nmi_out, 1, "nmi passes when idle");
    rd(8'h0C); chk(rd_v, 32'h0, "status reset");
    rd(8'h14); chk(32'(resp), 32'h2, "unmapped read");
    wr(8'h14, 32'h1); chk(32'(resp), 32'h2, "unmapped write");
    wr(8'h00, 32'h01); rd(8'h00); chk(rd_v, 32'h0, "program without enable");
    for (int f = 1; f <= 5; f++) begin
      wr(8'h00, 32'h40); wr(8'h00, 32'h41); settle();
      chk(pm, 1, "program mode"); chk(nmi_out, 0, "nmi blocked");
      @(posedge clock) cmd <= 3'(f);
      @(posedge clock) cmd <= 3'h0;
      settle();
      rd(8'h0C); chk(rd_v & 32'h1, f < 5, "error flag");
      chk(pm, f == 5, "abort"); rd(8'h00); chk(rd_v, 32'h41, "kept");
      wr(8'h00, 32'h41); settle(); chk(pm, f == 5, "no reentry");
      wr(8'h00, 32'h4C); settle(); chk(pvm, 1, "verify"); chk(evm, 1, "erase verify");
      pulse(f % 2);
      rd(8'h0C); chk(rd_v & 32'h1, 0, "flag released");
      rd(8'h00); chk(rd_v, 32'h0, "ctrl cleared");
    end
    wr(8'h00, 32'h40); wr(8'h00, 32'h41); wr(8'h04, 32'h5A);
    @(posedge clock) cmd <= 3'h1;
    @(posedge clock) cmd <= 3'h0;
    @(posedge clock) sws <= 1;
    @(posedge clock) sws <= 0;
    settle();
    rd(8'h00); chk(rd_v, 32'h0, "sw standby ctrl one");
    rd(8'h04); chk(rd_v, 32'h0, "sw standby ctrl two");
    rd(8'h0C); chk(rd_v & 32'h1, 1, "flag kept in sw standby");
    nrst <= 0;
    repeat (20) @(posedge clock);
    nrst <= 1;
    settle();
    rd(8'h0C); chk(rd_v & 32'h1, 0, "flag released by reset");
    wr(8'h00, 32'h40); wr(8'h08, 32'h0); wr(8'h00, 32'h42); settle();
    chk(em, 0, "no block");
    wr(8'h08, 32'h4); settle(); chk(blk_en, 8'h04, "block enable");
    we_pin <= 0; settle(); chk(em, 0, "pin low erase");
    rd(8'h00); chk(rd_v, 32'h0, "pin low ctrl");
    rd(8'h08); chk(rd_v, 32'h0, "pin low select");
    we_pin <= 1;
    wr(8'h10, 32'h5); cpu_req <= 1; cpu_addr <= 24'h000900; settle();
    chk(hit, 1, "window hit"); chk(ofs, 10'h100, "window offset");
    cpu_addr <= 24'hFFF3FF; settle(); chk(hit, 1, "ram hit"); chk(ofs, 10'h3FF, "ram ofs");
    cpu_addr <= 24'h000C00; settle(); chk(hit, 0, "window end");
    wr(8'h00, 32'h40); wr(8'h00, 32'h41); settle(); chk(pm, 0, "overlay blocks");
    ce <= 0; we_pin <= 0; settle(); ce <= 1; we_pin <= 1;
    rd(8'h00); chk(rd_v, 32'h41, "frozen while disabled");
    cpu_addr <= 24'h000800; we_pin <= 0; settle(); chk(hit, 0, "overlay removed");
    close_out();
  end
endmodule : testbench
`default_nettype wire
